// *** core/isq_sequencer.sv ***
// instruction sequencer with program counter and wake timing
`timescale 1ns/100ps
module isq_sequencer
    import isq_pkg::*;
(
    // clock and reset
    input  wire logic               clock,
    input  wire logic               sys_rst,
    input  wire logic               reset_pin_n,
    // program memory
    output logic [PC_W-1:0]         rom_addr,
    input  wire logic [ROM_W-1:0]   rom_data,
    output logic [ROM_W-1:0]        instr,
    output logic                    instr_valid,
    // execute unit requests
    input  wire logic [2:0]         exec_op,
    input  wire logic [PC_W-1:0]    exec_target,
    input  wire logic [7:0]         pc_low_byte,
    input  wire logic               call_push,
    input  wire logic               skip_met,
    // interrupts
    input  wire logic               ext_int_pin,
    input  wire logic               timer_ovf,
    input  wire logic               int_enable,
    input  wire logic               stack_full,
    output logic                    int_ack,
    output logic [PC_W-1:0]         ret_addr,
    // halt and wake
    input  wire logic               wake_event,
    output logic                    halted,
    // oscillator
    input  wire logic               rc_mode,
    output logic                    osc_out_pin,
    output logic [3:0]              phase_out
);
    ////////////////////////////////////////////////////////////////////
    logic             rst;
    logic [3:0]       phase;
    logic             cycle_end;
    logic [PC_W-1:0]  pc;
    logic [PC_W-1:0]  next_pc;
    logic             flush;
    logic             ext_prev;
    logic             ext_pend;
    logic             tmr_pend;
    logic             take_ext;
    logic             take_tmr;
    logic [WAKE_W-1:0] wake_cnt;
    isq_state_e       state;
    isq_op_e          op;

    assign rst = sys_rst | ~reset_pin_n;
    assign op  = isq_op_e'(exec_op);

    isq_phase_gen isq_phase_gen_i (
        .clock     (clock),
        .rst       (rst),
        .phase     (phase),
        .cycle_end (cycle_end)
    );

    ////////////////////////////////////////////////////////////////////
    // falling edge capture
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_prev <= 1'b1;
        end else begin
            ext_prev <= ext_int_pin;
        end
    end

    // vector gating; request stays pending while stack full
    assign take_ext = cycle_end && state == ISQ_RUN && !flush &&
                      ext_pend && int_enable && !stack_full;
    assign take_tmr = cycle_end && state == ISQ_RUN && !flush &&
                      !take_ext && tmr_pend && int_enable && !stack_full;

    // set wins over the acknowledge clear
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            ext_pend <= 1'b0;
            tmr_pend <= 1'b0;
        end else begin
            ext_pend <= (ext_prev && !ext_int_pin) || (ext_pend && !take_ext);
            tmr_pend <= timer_ovf || (tmr_pend && !take_tmr);
        end
    end

    ////////////////////////////////////////////////////////////////////
    // halt and wake
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            state    <= ISQ_RUN;
            wake_cnt <= '0;
        end else begin
            case (state)
                ISQ_RUN: begin
                    if (cycle_end && instr_valid && op == ISQ_HALT) begin
                        state <= ISQ_HALTED;
                    end
                end
                ISQ_HALTED: begin
                    wake_cnt <= '0;
                    if (wake_event || ext_pend || tmr_pend) begin
                        state <= ISQ_WAKE;
                    end
                end
                ISQ_WAKE: begin
                    wake_cnt <= WAKE_W'(wake_cnt + 1'b1);
                    if (wake_cnt == WAKE_LAST) begin
                        state <= ISQ_RUN;
                    end
                end
                default: state <= ISQ_RUN;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////
    // ops that redirect the fetch stream
    function automatic logic is_transfer(input isq_op_e o, input logic s);
        return o == ISQ_JUMP || o == ISQ_RET || o == ISQ_LOW_BYTE ||
               (o == ISQ_SKIP && s);
    endfunction

    always_comb begin
        next_pc = pc;
        if (take_ext) begin
            next_pc = VEC_EXT;
        end else if (take_tmr) begin
            next_pc = VEC_TIMER;
        end else if (instr_valid && !flush) begin
            case (op)
                ISQ_JUMP: next_pc = exec_target;
                ISQ_RET:  next_pc = exec_target;
                ISQ_LOW_BYTE: next_pc = {pc[PC_W-1:PAGE_LSB], pc_low_byte};
                ISQ_SKIP: next_pc = skip_met ? isq_inc(pc) : pc;
                default:  next_pc = pc;
            endcase
        end
    end

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            pc          <= VEC_RESET;
            flush       <= 1'b0;
            instr       <= '0;
            instr_valid <= 1'b0;
            int_ack     <= 1'b0;
            ret_addr    <= '0;
        end else begin
            int_ack <= 1'b0;
            if (cycle_end && state == ISQ_RUN) begin
                instr       <= rom_data;
                flush       <= 1'b0;
                instr_valid <= 1'b1;
                pc          <= isq_inc(next_pc);
                if (take_ext || take_tmr ||
                    (instr_valid && !flush && is_transfer(op, skip_met))) begin
                    // fetched word is stale: next cycle becomes dummy
                    flush       <= 1'b1;
                    instr_valid <= 1'b0;
                    pc          <= next_pc;
                end
                if (take_ext || take_tmr || (instr_valid && !flush &&
                    op == ISQ_JUMP && call_push)) begin
                    ret_addr <= pc;
                end
                if (take_ext || take_tmr) begin
                    int_ack <= 1'b1;
                end
            end
        end
    end

    assign rom_addr = pc;

    ////////////////////////////////////////////////////////////////////
    // quarter rate out
    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            osc_out_pin <= 1'b0;
            phase_out   <= 4'h1;
            halted      <= 1'b0;
        end else begin
            osc_out_pin <= rc_mode & (phase[1] | phase[2]);
            phase_out   <= phase;
            halted      <= (state != ISQ_RUN);
        end
    end

    ////////////////////////////////////////////////////////////////////
    sequence s_edge;
        ext_prev && !ext_int_pin;
    endsequence

    a_edge_pend: assert property (@(posedge clock) disable iff (rst)
        s_edge |=> ext_pend)
        else $error("falling edge not registered");
    a_vec_ext: assert property (@(posedge clock) disable iff (rst)
        take_ext |=> pc == VEC_EXT && flush)
        else $error("external vector not loaded");
    a_vec_tmr: assert property (@(posedge clock) disable iff (rst)
        take_tmr |=> pc == VEC_TIMER)
        else $error("timer vector not loaded");
    a_stack_block: assert property (@(posedge clock) disable iff (rst)
        stack_full |-> !take_ext && !take_tmr)
        else $error("interrupt taken with full stack");
    a_pc_step: assert property (@(posedge clock) disable iff (rst)
        cycle_end && state == ISQ_RUN && !flush && !take_ext && !take_tmr &&
        (!instr_valid || op == ISQ_NONE)
        |=> pc == isq_inc($past(pc)))
        else $error("program counter did not step by one");
    a_low_page: assert property (@(posedge clock) disable iff (rst)
        cycle_end && state == ISQ_RUN && instr_valid && !flush &&
        op == ISQ_LOW_BYTE && !take_ext && !take_tmr
        |=> pc[PC_W-1:PAGE_LSB] == $past(pc[PC_W-1:PAGE_LSB]))
        else $error("low byte write changed page");
    a_dummy_cycle: assert property (@(posedge clock) disable iff (rst)
        flush && cycle_end && state == ISQ_RUN |=> instr_valid && !flush)
        else $error("dummy cycle wrongly handled");
    a_osc_quarter: assert property (@(posedge clock) disable iff (rst)
        rc_mode && phase[1] |=> osc_out_pin)
        else $error("oscillator output not at quarter rate");
    a_osc_off: assert property (@(posedge clock) disable iff (rst)
        !rc_mode |=> !osc_out_pin)
        else $error("oscillator output driven outside rc mode");

    ////////////////////////////////////////////////////////////////////
    // an op is acted on only at a cycle end with a live, unflushed word
    sequence s_exec;
        cycle_end && state == ISQ_RUN && instr_valid && !flush &&
        !take_ext && !take_tmr;
    endsequence

    a_xfer_dummy: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 is_transfer(op, skip_met) |=> flush && !instr_valid)
        else $error("transfer did not insert a dummy cycle");
    a_jump_tgt: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_JUMP) |=> pc == $past(exec_target))
        else $error("jump target not loaded");
    a_ret_tgt: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_RET) |=> pc == $past(exec_target))
        else $error("return target not loaded");
    a_low_byte: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_LOW_BYTE)
        |=> pc[PAGE_LSB-1:0] == $past(pc_low_byte))
        else $error("low byte not loaded");
    a_skip_two: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_SKIP && skip_met) |=> pc == isq_inc($past(pc)))
        else $error("met skip did not pass over one word");
    a_skip_stay: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_SKIP && !skip_met) |=> instr_valid && !flush)
        else $error("unmet skip discarded a word");
    a_call_save: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_JUMP && call_push) |=> ret_addr == $past(pc))
        else $error("call return address not kept");
    a_int_save: assert property (@(posedge clock) disable iff (rst)
        take_ext || take_tmr |=> int_ack && ret_addr == $past(pc))
        else $error("interrupt return address not kept");
    a_int_pulse: assert property (@(posedge clock) disable iff (rst)
        int_ack |=> !int_ack)
        else $error("interrupt acknowledge longer than one cycle");
    a_tmr_pend: assert property (@(posedge clock) disable iff (rst)
        timer_ovf |=> tmr_pend)
        else $error("timer overflow not registered");
    a_fetch_word: assert property (@(posedge clock) disable iff (rst)
        cycle_end && state == ISQ_RUN |=> instr == $past(rom_data))
        else $error("fetched word not handed to execute");
    a_halt_enter: assert property (@(posedge clock) disable iff (rst)
        s_exec ##0 (op == ISQ_HALT) |=> state == ISQ_HALTED)
        else $error("halt op not obeyed");
    a_halt_flag: assert property (@(posedge clock) disable iff (rst)
        state != ISQ_RUN |=> halted)
        else $error("halted flag not shown");
    a_halt_freeze: assert property (@(posedge clock) disable iff (rst)
        state != ISQ_RUN |=> $stable(pc))
        else $error("program counter moved while stopped");

    ////////////////////////////////////////////////////////////////////
    // start-up wait age; kept apart from wake_cnt so the
    // check does not lean on the counter it guards
    logic [WAKE_W-1:0] wake_age;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            wake_age <= '0;
        end else if (state == ISQ_WAKE) begin
            wake_age <= WAKE_W'(wake_age + 1'b1);
        end else begin
            wake_age <= '0;
        end
    end

    a_wake_hold: assert property (@(posedge clock) disable iff (rst)
        state == ISQ_WAKE && wake_age != WAKE_LAST |=> state == ISQ_WAKE)
        else $error("wake delay ended early");
    a_wake_end: assert property (@(posedge clock) disable iff (rst)
        state == ISQ_WAKE && wake_age == WAKE_LAST |=> state == ISQ_RUN)
        else $error("wake delay overran");
endmodule // isq_sequencer

// *** core/isq_pkg.sv ***
// constants and types shared by the instruction sequencer
// Notes on behaviour
// - four phase clocks per instruction cycle
// - fetch overlaps execution of previous instruction
// - program counter changes cost two cycles
// - program counter steps by one per fetch
// - eleven-bit counter spans 2048 words
// - load counter on every transfer event
// - falling edge on interrupt pin requests
// - wake from halt waits 1024 clocks
// - oscillator output pin runs quarter rate
// - low reset pin holds sequencer reset
// - first fetch after reset from 000H
// - vectors 004H and 008H when allowed
// - met skip discards prefetch, dummy cycle
// - low byte write keeps page bits
package isq_pkg;
    localparam int          PC_W          = 11;
    localparam int          ROM_W         = 14;
    localparam int          PH_W          = 2;
    localparam logic [1:0]  PH_LAST       = 2'h3;
    localparam logic [10:0] VEC_RESET     = 11'h000;
    localparam logic [10:0] VEC_EXT       = 11'h004;
    localparam logic [10:0] VEC_TIMER     = 11'h008;
    localparam int          PAGE_LSB      = 8;
    localparam int          T_SYS_NS      = 10;
    localparam int          WAKE_STARTUP_DELAY = 1024;
    localparam int          WAKE_CYC      = WAKE_STARTUP_DELAY;
    localparam int          WAKE_W        = 11;
    localparam logic [10:0] WAKE_LAST     = 11'(WAKE_CYC - 1);

    typedef enum logic [2:0] {
        ISQ_NONE   = 3'h0,
        ISQ_JUMP   = 3'h1,
        ISQ_SKIP   = 3'h2,
        ISQ_LOW_BYTE = 3'h3,
        ISQ_RET    = 3'h4,
        ISQ_HALT   = 3'h5
    } isq_op_e;

    typedef enum logic [1:0] {
        ISQ_RUN    = 2'h0,
        ISQ_HALTED = 2'h1,
        ISQ_WAKE   = 2'h2
    } isq_state_e;

    function automatic logic [10:0] isq_inc(input logic [10:0] pc);
        return 11'(pc + 11'h001);
    endfunction
endpackage

// *** core/isq_phase_gen.sv ***
// four phase clock generator of the sequencer
`timescale 1ns/100ps
module isq_phase_gen
    import isq_pkg::*;
(
    // clock and reset
    input  wire logic        clock,
    input  wire logic        rst,
    // phase outputs
    output logic [3:0]       phase,
    output logic             cycle_end
);
    logic [1:0] count;

    always_ff @(posedge clock or posedge rst) begin
        if (rst) begin
            count <= 2'h0;
        end else begin
            count <= 2'(count + 2'h1);
        end
    end

    // one-hot phases never overlap
    always_comb begin
        phase = 4'h0;
        phase[count] = 1'b1;
        cycle_end = (count == PH_LAST);
    end

    a_phase_wrap: assert property (@(posedge clock) disable iff (rst)
        (count == PH_LAST) |=> (count == 2'h0))
        else $error("phase count did not wrap after fourth phase");
endmodule // isq_phase_gen

// *** testbench/isq_rom_model.sv ***
// program store model answering fetches from the sequencer
`timescale 1ns/100ps
module isq_rom_model
    import isq_pkg::*;
(
    // fetch port
    input  wire logic [PC_W-1:0]  rom_addr,
    output logic [ROM_W-1:0]      rom_data
);
    // full address span
    // each word holds its own address so the bench sees what was fetched
    assign rom_data = {3'h5, rom_addr};
endmodule // isq_rom_model

// *** testbench/instruction_sequencer_pc_bench.sv ***
// self-checking bench for the instruction sequencer
`timescale 1ns/100ps
`define CHK(w, e, g) begin total_checks++; if ((g) !== (e)) begin \
    n_mismatch++; $display("FAIL %s exp %0h got %0h", w, e, g); end end
module instruction_sequencer_pc_bench
    import isq_pkg::*;
;
    logic              clock = 1'b0;
    logic              sys_rst, reset_pin_n, instr_valid, call_push;
    logic              skip_met, ext_int_pin, timer_ovf, int_enable;
    logic              stack_full, int_ack, wake_event, halted;
    logic              rc_mode, osc_out_pin, prev;
    logic [PC_W-1:0]   rom_addr, exec_target, ret_addr, a;
    logic [ROM_W-1:0]  rom_data, instr;
    logic [2:0]        exec_op;
    logic [7:0]        pc_low_byte;
    logic [3:0]        phase_out, p;
    int                n_mismatch = 0, total_checks = 0, cycles = 0, i;

    always #5 clock = ~clock;

    isq_rom_model isq_rom_model_i (.rom_addr(rom_addr), .rom_data(rom_data));
    isq_sequencer isq_sequencer_i (
        .clock(clock), .sys_rst(sys_rst), .reset_pin_n(reset_pin_n),
        .rom_addr(rom_addr), .rom_data(rom_data), .instr(instr),
        .instr_valid(instr_valid), .exec_op(exec_op),
        .exec_target(exec_target), .pc_low_byte(pc_low_byte),
        .call_push(call_push), .skip_met(skip_met),
        .ext_int_pin(ext_int_pin), .timer_ovf(timer_ovf),
        .int_enable(int_enable), .stack_full(stack_full),
        .int_ack(int_ack), .ret_addr(ret_addr), .wake_event(wake_event),
        .halted(halted), .rc_mode(rc_mode), .osc_out_pin(osc_out_pin),
        .phase_out(phase_out));

    ////////////////////////////////////////////////////////////////////
    task automatic end_of_test();
        $display("checks %0d mismatches %0d", total_checks, n_mismatch);
        if (n_mismatch == 0 && total_checks > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    // a hang costs a mismatch rather than a silent stall
    always @(posedge clock) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            n_mismatch++;
            end_of_test();
        end
    end

    task automatic wait_valid();
        int k;
        k = 0;
        @(negedge clock);
        while (instr_valid !== 1'b1 && k < 20) begin
            @(negedge clock);
            k++;
        end
    endtask

    // lands just after a fresh word so ops line up with cycle ends
    task automatic next_instr();
        int k;
        k = 0;
        a = instr[10:0];
        while (instr[10:0] === a && k < 20) begin
            @(negedge clock);
            k++;
        end
    endtask

    task automatic op_run(input logic [2:0] op, input logic [10:0] tgt,
                          input logic s, input logic [10:0] exp);
        int k;
        k = 0;
        exec_op = op;
        exec_target = tgt;
        pc_low_byte = tgt[7:0];
        skip_met = s;
        call_push = (op == 3'h1);
        while (instr_valid !== 1'b0 && k < 12) begin
            @(negedge clock);
            k++;
        end
        exec_op = 3'h0;
        skip_met = 1'b0;
        call_push = 1'b0;
        `CHK("dummy", 1'b0, instr_valid)
        // the discarded prefetch is the word a call returns to
        if (op == 3'h1)
            `CHK("call ret", instr[10:0], ret_addr)
        wait_valid();
        `CHK("target", exp, instr[10:0])
        repeat (4) @(negedge clock);
        `CHK("next", 11'(exp + 11'h001), instr[10:0])
        $display("test op %0h done", op);
    endtask

    task automatic wait_ack(output int k);
        k = 0;
        while (int_ack !== 1'b1 && k < 40) begin
            @(negedge clock);
            k++;
        end
    endtask

    task automatic irq(input logic ext, input logic blk,
                       input logic [10:0] vec);
        int k;
        // the timer is held back by a full stack, the pin by a cleared enable
        stack_full = blk && !ext;
        int_enable = !(blk && ext);
        if (ext)
            ext_int_pin = 1'b0;
        else
            timer_ovf = 1'b1;
        @(negedge clock);
        timer_ovf = 1'b0;
        wait_ack(k);
        if (blk) begin
            `CHK("held", 40, k)
            stack_full = 1'b0;
            int_enable = 1'b1;
            wait_ack(k);
        end
        `CHK("ack", 1'b1, int_ack)
        `CHK("ret", instr[10:0], ret_addr)
        wait_valid();
        `CHK("vector", vec, instr[10:0])
        // source keeps the pin low a full microsecond
        repeat (100) @(negedge clock);
        ext_int_pin = 1'b1;
        $display("test irq %0h done", vec);
    endtask

    ////////////////////////////////////////////////////////////////////
    initial begin
        {call_push, skip_met, timer_ovf, stack_full} = 4'h0;
        {wake_event, rc_mode, exec_op} = 5'h00;
        {exec_target, pc_low_byte} = 19'h00000;
        {sys_rst, reset_pin_n, ext_int_pin, int_enable} = 4'hF;
        repeat (20) @(negedge clock);
        `CHK("rst addr", 11'h000, rom_addr)
        `CHK("rst phase", 4'h1, phase_out)
        sys_rst = 1'b0;
        wait_valid();
        `CHK("first", 11'h000, instr[10:0])
        repeat (4) @(negedge clock);
        `CHK("second", 11'h001, instr[10:0])
        p = phase_out;
        repeat (4) @(negedge clock);
        `CHK("phase period", p, phase_out)
        `CHK("one hot", 1, $countones(phase_out))
        $display("test reset done");
        op_run(3'h1, 11'h155, 1'b0, 11'h155);
        op_run(3'h2, 11'h000, 1'b1, 11'(instr[10:0] + 11'h002));
        a = 11'(instr[10:0] + 11'h001);
        op_run(3'h3, 11'h03C, 1'b0, {a[10:8], 8'h3C});
        op_run(3'h4, 11'h2A0, 1'b0, 11'h2A0);
        irq(1'b1, 1'b0, VEC_EXT);
        irq(1'b0, 1'b1, VEC_TIMER);
        irq(1'b1, 1'b1, VEC_EXT);
        next_instr();
        exec_op = 3'h5;
        i = 0;
        while (halted !== 1'b1 && i < 12) begin
            @(negedge clock);
            i++;
        end
        exec_op = 3'h0;
        repeat (50) @(negedge clock);
        `CHK("halt holds", 1'b1, halted)
        wake_event = 1'b1;
        i = 0;
        while (halted !== 1'b0 && i < 1100) begin
            @(negedge clock);
            i++;
        end
        wake_event = 1'b0;
        `CHK("wake delay", 1'b1, i >= 1023 && i <= 1028)
        $display("test halt done");
        reset_pin_n = 1'b0;
        repeat (2) @(negedge clock);
        `CHK("pin rst addr", 11'h000, rom_addr)
        `CHK("pin rst valid", 1'b0, instr_valid)
        reset_pin_n = 1'b1;
        wait_valid();
        `CHK("restart", 11'h000, instr[10:0])
        `CHK("osc off", 1'b0, osc_out_pin)
        $display("test pin reset done");
        rc_mode = 1'b1;
        repeat (8) @(negedge clock);
        i = 0;
        prev = osc_out_pin;
        repeat (40) begin
            @(negedge clock);
            if (osc_out_pin === 1'b1 && prev === 1'b0)
                i++;
            prev = osc_out_pin;
        end
        `CHK("osc rises", 10, i)
        $display("test osc done");
        end_of_test();
    end
endmodule // instruction_sequencer_pc_bench
